// *** iqa_pkg.sv ***
// Constants and types shared by the I/Q input data assembler.
package iqa_pkg;
	// ---------------------------------------------------------------
	// Register map
	// ---------------------------------------------------------------
	localparam logic [7:0] IQA_ADDR_CFG = 8'h01;
	localparam logic [7:0] IQA_ADDR_PROFILE = 8'h06;
	localparam logic [7:0] IQA_ADDR_FORMAT = 8'h20;
	localparam logic [7:0] IQA_ADDR_CIC = 8'h21;
	localparam logic [7:0] IQA_ADDR_STATUS = 8'h22;
	localparam logic [7:0] IQA_ADDR_CMD = 8'h23;
	// ---------------------------------------------------------------
	// Field positions and reset values
	// ---------------------------------------------------------------
	localparam int IQA_CONT_BIT = 6;
	localparam int IQA_HB3_BYPASS_BIT = 0;
	localparam int IQA_MULT_EN_BIT = 7;
	localparam int IQA_LOCK_BIT = 0;
	localparam int IQA_OVF_BIT = 1;
	localparam int IQA_RESET_CMD_BIT = 0;
	localparam logic [7:0] IQA_CFG_RST = 8'h00;
	localparam logic [7:0] IQA_PROFILE_RST = 8'h00;
	localparam logic [1:0] IQA_FORMAT_RST = 2'h0;
	localparam logic [5:0] IQA_CIC_RST = 6'h02;
	localparam logic [5:0] IQA_CIC_MIN = 6'h02;
	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam int IQA_CLK_HZ = 10000000;
	localparam int IQA_SETTLE_US = 1000;
	localparam int IQA_SETTLE_CYC = IQA_SETTLE_US * (IQA_CLK_HZ / 1000000);
	// ---------------------------------------------------------------
	// Types
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		IQA_FMT_FULL,
		IQA_FMT_HALF,
		IQA_FMT_QUARTER,
		IQA_FMT_RSVD
	} iqa_format_t;
endpackage

// *** iqa_period_gen.sv ***
// Word period counter that restarts on a strobe rising edge.
`timescale 1ns/100ps
module iqa_period_gen import iqa_pkg::*; #(
	parameter int CW = 9
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic restart,
	input wire logic [CW-1:0] period,
	output logic mid_tick,
	output logic end_tick
);
	logic [CW-1:0] cnt_q;

	// Counting from the edge keeps the capture point centred.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= '0;
		end else if (restart || cnt_q >= period - 1'b1) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_q + 1'b1;
		end
	end

	// The counter clears one clock after the rise is seen, so the capture sits one
	// clock before the half count, which keeps it in the middle of the word.
	assign mid_tick = !restart && (cnt_q == (period >> 1) - 1'b1);
	assign end_tick = !restart && (cnt_q >= period - 1'b1);
endmodule // iqa_period_gen

// *** iqa_assembler.sv ***
// I/Q input data assembler for the quadrature upconverter.
//
// The implementer's own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/100ps
module iqa_assembler import iqa_pkg::*; #(
	parameter int CW = 9
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic tx_frame_strobe,
	input wire logic [11:0] data_in,
	input wire logic pll_locked,
	output logic [11:0] i_out,
	output logic [11:0] q_out,
	output logic iq_valid,
	output logic cic_overflow
);
	// ---------------------------------------------------------------
	// Pin synchronisers
	// ---------------------------------------------------------------
	logic strb_m_q, strb_s_q, strb_d_q, lock_m_q, lock_s_q;
	logic [11:0] din_m_q, din_s_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			strb_m_q <= 1'b0;
			strb_s_q <= 1'b0;
			strb_d_q <= 1'b0;
			din_m_q <= 12'h000;
			din_s_q <= 12'h000;
			lock_m_q <= 1'b0;
			lock_s_q <= 1'b0;
		end else begin
			strb_m_q <= tx_frame_strobe;
			strb_s_q <= strb_m_q;
			strb_d_q <= strb_s_q;
			din_m_q <= data_in;
			din_s_q <= din_m_q;
			lock_m_q <= pll_locked;
			lock_s_q <= lock_m_q;
		end
	end

	logic strb_rise;
	assign strb_rise = strb_s_q && !strb_d_q;

	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	logic [7:0] cfg_q, prof_q;
	logic [1:0] fmt_q;
	logic [5:0] cic_q;
	logic ovf_q, rst_cmd;
	logic cont_mode, hb3_bypass, mult_en;

	assign cont_mode = cfg_q[IQA_CONT_BIT];
	assign mult_en = cfg_q[IQA_MULT_EN_BIT];
	assign hb3_bypass = prof_q[IQA_HB3_BYPASS_BIT];
	assign rst_cmd = reg_wr && reg_addr == IQA_ADDR_CMD &&
		reg_wdata[IQA_RESET_CMD_BIT];

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_q <= IQA_CFG_RST;
			prof_q <= IQA_PROFILE_RST;
			fmt_q <= IQA_FORMAT_RST;
			cic_q <= IQA_CIC_RST;
		end else if (reg_wr) begin
			case (reg_addr)
				IQA_ADDR_CFG: cfg_q <= reg_wdata;
				IQA_ADDR_PROFILE: prof_q <= reg_wdata;
				IQA_ADDR_FORMAT: fmt_q <= reg_wdata[1:0];
				IQA_ADDR_CIC: begin
					if (reg_wdata[5:0] >= IQA_CIC_MIN) begin
						cic_q <= reg_wdata[5:0];
					end
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
				IQA_ADDR_CFG: reg_rdata <= cfg_q;
				IQA_ADDR_PROFILE: reg_rdata <= prof_q;
				IQA_ADDR_FORMAT: reg_rdata <= {6'h00, fmt_q};
				IQA_ADDR_CIC: reg_rdata <= {2'h0, cic_q};
				IQA_ADDR_STATUS: reg_rdata <= {6'h00, ovf_q, lock_s_q};
				default: reg_rdata <= 8'h00;
			endcase
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	// Overflow is sticky; only the reset command clears it, and a fresh
	// cause in the same cycle wins.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ovf_q <= 1'b0;
		end else if (cont_mode && mult_en && !lock_s_q) begin
			ovf_q <= 1'b1;
		end else if (rst_cmd) begin
			ovf_q <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// Word period
	// ---------------------------------------------------------------
	iqa_format_t fmt;
	logic [CW-1:0] period;
	logic mid_tick, end_tick;

	assign fmt = iqa_format_t'(fmt_q);

	// Continuous mode forces full word; quarter word ignores HB3 bypass.
	always_comb begin
		if (cont_mode || fmt == IQA_FMT_FULL || fmt == IQA_FMT_HALF) begin
			period = hb3_bypass ? CW'({cic_q, 1'b0}) :
				CW'({cic_q, 2'b00});
		end else begin
			period = CW'(cic_q);
		end
	end

	iqa_period_gen #(.CW(CW)) u_period (
		.clk(clk),
		.rst_n(rst_n),
		.restart(strb_rise),
		.period(period),
		.mid_tick(mid_tick),
		.end_tick(end_tick)
	);

	// ---------------------------------------------------------------
	// Assembly
	// ---------------------------------------------------------------
	logic synced_q, low_seen_q, zero_q;
	logic [2:0] slice_q;
	logic [11:0] i_acc_q, q_acc_q;
	logic [2:0] last_slice;
	logic [7:0] mode_q;
	logic mode_chg;

	assign last_slice = cont_mode ? 3'h1 :
		fmt == IQA_FMT_HALF ? 3'h3 :
		fmt == IQA_FMT_QUARTER ? 3'h7 : 3'h1;
	assign mode_chg = mode_q != {cfg_q[IQA_CONT_BIT], fmt_q, prof_q[4:0]};

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_q <= 8'h00;
		end else begin
			mode_q <= {cfg_q[IQA_CONT_BIT], fmt_q, prof_q[4:0]};
		end
	end

	// Burst: a low strobe spanning a full period means the burst ended.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			low_seen_q <= 1'b0;
			zero_q <= 1'b0;
		end else if (strb_rise || cont_mode) begin
			low_seen_q <= 1'b0;
			zero_q <= 1'b0;
		end else if (end_tick) begin
			low_seen_q <= !strb_s_q;
			zero_q <= zero_q || (low_seen_q && !strb_s_q);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			synced_q <= 1'b0;
			slice_q <= 3'h0;
			i_acc_q <= 12'h000;
			q_acc_q <= 12'h000;
		end else if (mode_chg) begin
			synced_q <= 1'b0;
			slice_q <= 3'h0;
		end else if (strb_rise) begin
			synced_q <= 1'b1;
			slice_q <= 3'h0;
		end else if (synced_q && mid_tick) begin
			if (cont_mode) begin
				// Strobe level says which half of the pair is on the bus.
				if (strb_s_q) begin
					i_acc_q <= din_s_q;
				end else begin
					q_acc_q <= din_s_q;
				end
				slice_q <= strb_s_q ? 3'h1 : 3'h0;
			end else begin
				case (fmt)
					IQA_FMT_HALF: begin
						if (!slice_q[1]) begin
							i_acc_q <= {i_acc_q[5:0], din_s_q[11:6]};
						end else begin
							q_acc_q <= {q_acc_q[5:0], din_s_q[11:6]};
						end
					end
					IQA_FMT_QUARTER: begin
						if (!slice_q[2]) begin
							i_acc_q <= {i_acc_q[8:0], din_s_q[11:9]};
						end else begin
							q_acc_q <= {q_acc_q[8:0], din_s_q[11:9]};
						end
					end
					default: begin
						if (slice_q[0]) begin
							q_acc_q <= din_s_q;
						end else begin
							i_acc_q <= din_s_q;
						end
					end
				endcase
				slice_q <= (slice_q == last_slice) ? 3'h0 : slice_q + 3'h1;
			end
		end
	end

	// ---------------------------------------------------------------
	// Output pair
	// ---------------------------------------------------------------
	logic pair_done;
	assign pair_done = synced_q && !mode_chg && !strb_rise && mid_tick &&
		(cont_mode ? !strb_s_q : slice_q == last_slice);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			i_out <= 12'h000;
			q_out <= 12'h000;
			iq_valid <= 1'b0;
		end else begin
			iq_valid <= pair_done;
			if (pair_done) begin
				// Zeros replace bus data once the burst has ended.
				i_out <= zero_q ? 12'h000 : i_acc_q;
				q_out <= zero_q ? 12'h000 : (cont_mode ||
					fmt == IQA_FMT_FULL ? din_s_q :
					fmt == IQA_FMT_HALF ? {q_acc_q[5:0], din_s_q[11:6]} :
					{q_acc_q[8:0], din_s_q[11:9]});
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cic_overflow <= 1'b0;
		end else begin
			cic_overflow <= ovf_q;
		end
	end

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	a_valid_one_cycle: assert property (
		@(posedge clk) disable iff (!rst_n)
		iq_valid |=> !iq_valid) else $error("valid longer than one cycle");
	a_ovf_sticky: assert property (
		@(posedge clk) disable iff (!rst_n)
		ovf_q && !rst_cmd |=> ovf_q) else $error("overflow lost");
	a_ovf_out: assert property (
		@(posedge clk) disable iff (!rst_n)
		ovf_q |=> cic_overflow) else $error("overflow not shown");
	a_zero_data: assert property (
		@(posedge clk) disable iff (!rst_n)
		pair_done && zero_q |=> i_out == 12'h000 && q_out == 12'h000)
		else $error("zero insertion missing");
	a_no_zero_cont: assert property (
		@(posedge clk) disable iff (!rst_n)
		cont_mode && pair_done |=> q_out == $past(din_s_q))
		else $error("zeros in continuous");
	a_hold_unsync: assert property (
		@(posedge clk) disable iff (!rst_n)
		!synced_q |=> !iq_valid) else $error("pair before sync");
	a_rise_restart: assert property (
		@(posedge clk) disable iff (!rst_n)
		strb_rise && !mode_chg |=> synced_q && slice_q == 3'h0)
		else $error("no resync on rise");
	a_cont_bit: assert property (
		@(posedge clk) disable iff (!rst_n)
		reg_wr && reg_addr == IQA_ADDR_CFG |=>
		cont_mode == $past(reg_wdata[IQA_CONT_BIT]))
		else $error("continuous bit not stored");
	a_hb3_bit: assert property (
		@(posedge clk) disable iff (!rst_n)
		reg_wr && reg_addr == IQA_ADDR_PROFILE |=>
		hb3_bypass == $past(reg_wdata[IQA_HB3_BYPASS_BIT]))
		else $error("bypass bit not stored");
endmodule // iqa_assembler

// *** iqa_src_model.sv ***
// Baseband source model driving the frame strobe and data pins.
`timescale 1ns/100ps
module iqa_src_model import iqa_pkg::*; (
	input wire logic clk,
	output logic tx_frame_strobe,
	output logic [11:0] data_in
);
	logic [11:0] iw [4];
	logic [11:0] qw [4];
	logic [11:0] last;
	initial begin
		tx_frame_strobe = 1'b0;
		data_in = 12'h000;
		last = 12'h000;
	end
	// One word slot of p clocks; signals change only right after an edge.
	task automatic put(input logic s, input logic [11:0] d, input int p);
		@(posedge clk);
		tx_frame_strobe <= s;
		data_in <= d;
		last = d;
		repeat (p - 1) @(posedge clk);
	endtask
	// Unused low lines carry junk so that leaking them shows at once.
	task automatic run(input int np, input int p, input iqa_format_t f,
		input logic cont, input logic alt);
		int sl;
		int w;
		logic [11:0] x;
		logic [11:0] d;
		sl = (f == IQA_FMT_FULL) ? 1 : (f == IQA_FMT_HALF) ? 2 : 4;
		w = 12 / sl;
		for (int k = 0; k < np; k++) begin
			for (int h = 0; h < 2; h++) begin
				x = h ? qw[k] : iw[k];
				for (int s = 0; s < sl; s++) begin
					d = 12'($urandom);
					for (int b = 0; b < w; b++)
						d[11 - b] = x[11 - s * w - b];
					put((cont || alt) ? (h == 0) : 1'b1, d, p);
				end
			end
		end
		// Released bus shows the inverse of the last word, not a copy.
		put(1'b0, ~last, 1);
	endtask
endmodule // iqa_src_model

// *** tb.sv ***
// Self-checking testbench for the I/Q input data assembler.
`timescale 1ns/100ps
module tb import iqa_pkg::*;;
	localparam int N = 4;
	logic clk, rst_n, reg_wr, reg_rd, strb, pll_locked, iq_valid;
	logic cic_overflow, first;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	logic [11:0] din, i_out, q_out;
	logic [23:0] exp_q [$];
	logic [23:0] tail;
	int n_fail, n_checks, cyc, last_cyc, gap, ntail;
	always #50 clk = ~clk;
	always @(posedge clk) cyc <= cyc + 1;
	iqa_assembler iqa_assembler_i (.clk(clk), .rst_n(rst_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_frame_strobe(strb),
		.data_in(din), .pll_locked(pll_locked), .i_out(i_out),
		.q_out(q_out), .iq_valid(iq_valid), .cic_overflow(cic_overflow));
	iqa_src_model iqa_src_model_i (.clk(clk), .tx_frame_strobe(strb),
		.data_in(din));
	// ---------------------------------------------------------------
	// Checks and bus tasks
	// ---------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 chk("rdata", {24'h0, e}, {24'h0, reg_rdata});
	endtask
	// Word period in sample clocks keeps an integer ratio to the source.
	function automatic int word_period(input iqa_format_t f, input logic byp);
		return (f == IQA_FMT_QUARTER) ? N : (byp ? 2 * N : 4 * N);
	endfunction
	task print_verdict;
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// Pairs are matched in order; anything after the burst is tail.
	always @(negedge clk) begin
		if (iq_valid === 1'b1) begin
			if (exp_q.size() > 0) begin
				chk("pair", {8'h0, exp_q.pop_front()}, {8'h0, i_out, q_out});
				if (!first) chk("gap", 32'(gap), 32'(cyc - last_cyc));
				first = 1'b0;
				last_cyc = cyc;
			end else begin
				ntail++;
				tail = {i_out, q_out};
			end
		end
	end
	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	task automatic scen(input iqa_format_t f, input logic byp,
		input logic cont, input logic alt);
		int p;
		int sl;
		sl = (f == IQA_FMT_FULL) ? 1 : (f == IQA_FMT_HALF) ? 2 : 4;
		p = word_period(f, byp);
		wr(IQA_ADDR_FORMAT, {6'h00, f});
		wr(IQA_ADDR_PROFILE, {7'h00, byp});
		wr(IQA_ADDR_CFG, {1'b0, cont, 6'h00});
		rd(IQA_ADDR_CFG, {1'b0, cont, 6'h00});
		for (int k = 0; k < 4; k++) begin
			iqa_src_model_i.iw[k] = k ? 12'($urandom) : 12'h800;
			iqa_src_model_i.qw[k] = k ? 12'($urandom) & 12'hFFE : 12'h7FF;
			exp_q.push_back({iqa_src_model_i.iw[k], iqa_src_model_i.qw[k]});
		end
		first = 1'b1;
		gap = 2 * sl * p;
		ntail = 0;
		tail = 24'hFFFFFF;
		repeat (3 * p) @(posedge clk);
		iqa_src_model_i.run(4, p, f, cont, alt);
		repeat (12 * sl * p) @(posedge clk);
		chk("missing", 32'h0, 32'(exp_q.size()));
		exp_q.delete();
		if (cont) begin
			chk("static", 32'h1, 32'(tail != 24'h0));
		end else begin
			chk("zeros", 32'h0, {8'h0, tail});
			chk("tailcount", 32'h1, 32'(ntail > 0));
		end
	endtask
	initial begin
		clk = 1'b0;
		rst_n = 1'b0;
		{reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
		pll_locked = 1'b1;
		{n_fail, n_checks, cyc, last_cyc, ntail} = '0;
		void'($urandom(52));
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		rd(IQA_ADDR_CFG, 8'h00);
		rd(IQA_ADDR_PROFILE, 8'h00);
		rd(IQA_ADDR_CIC, 8'h02);
		rd(8'h30, 8'h00);
		wr(IQA_ADDR_CIC, 8'h01);
		rd(IQA_ADDR_CIC, 8'h02);
		wr(IQA_ADDR_CIC, 8'(N));
		rd(IQA_ADDR_CIC, 8'(N));
		for (int k = 0; k < 4; k++)
			iqa_src_model_i.put(1'b0, 12'($urandom), 20);
		chk("prestart", 32'h0, 32'(ntail));
		pll_locked <= 1'b0;
		wr(IQA_ADDR_CFG, 8'hC0);
		repeat (8) @(posedge clk);
		rd(IQA_ADDR_STATUS, 8'h02);
		wr(IQA_ADDR_CFG, 8'h00);
		repeat (8) @(posedge clk);
		chk("sticky", 32'h1, {31'h0, cic_overflow});
		wr(IQA_ADDR_CMD, 8'h01);
		repeat (4) @(posedge clk);
		chk("cleared", 32'h0, {31'h0, cic_overflow});
		pll_locked <= 1'b1;
		wr(IQA_ADDR_CFG, 8'h80);
		repeat (IQA_SETTLE_CYC) @(posedge clk);
		wr(IQA_ADDR_CFG, 8'hC0);
		repeat (8) @(posedge clk);
		rd(IQA_ADDR_STATUS, 8'h01);
		scen(IQA_FMT_FULL, 1'b0, 1'b0, 1'b0);
		scen(IQA_FMT_FULL, 1'b1, 1'b0, 1'b1);
		scen(IQA_FMT_HALF, 1'b0, 1'b0, 1'b0);
		scen(IQA_FMT_HALF, 1'b1, 1'b0, 1'b0);
		scen(IQA_FMT_QUARTER, 1'b0, 1'b0, 1'b0);
		scen(IQA_FMT_FULL, 1'b0, 1'b1, 1'b0);
		print_verdict();
	end
	initial begin
		#(40000 * 100);
		n_fail++;
		print_verdict();
	end
endmodule // tb
